// >>> rtl/ttac_pkg.sv
/*
  Constants and shared functions of the token time stamp and
  credited quantity codec.
  Assumes one clock, calendar fields given in binary, and an epoch origin
  that is always 1 January of the given year at 00:00.
*/
// Summary of operation
// - stamp is 24-bit count of elapsed minutes
// - origin date at midnight gives stamp zero
// - leap day every fourth year, centuries 400
// - stamp bit order, leftmost bit most significant
// - seconds truncated, never rounded
// - 00:01 stamp kept for special tokens
// - ordinary token at 00:01 gets one minute
// - same-meter burst stamps rise one minute each
// - after burst, stamps follow real time again
// - burst increment skips special application tokens
// - units 0.1 kWh, watt, 1e-5 currency
// - exponent bits 15:14, mantissa bits 13:0
// - quantity is mantissa scaled plus exponent offsets
// - encoder rounds quantity up for the customer
// - four exponent ranges up to 18201624

package ttac_pkg;

  // ==========================================================================
  // time stamp
  // ==========================================================================
  localparam int STAMP_W = 24;
  localparam int YEAR_W = 12;
  localparam logic [10:0] MIN_PER_DAY = 11'h5a0;
  localparam logic [5:0] MIN_PER_HOUR = 6'h3c;
  localparam logic [8:0] DAYS_PER_YEAR = 9'h16d;
  localparam logic [10:0] RESERVED_MIN = 11'h001;
  localparam logic [YEAR_W-1:0] YEAR_SPAN_MAX = 12'h028;
  localparam logic [3:0] MONTHS = 4'hc;
  localparam logic [3:0] FEB = 4'h2;
  localparam logic [YEAR_W-1:0] LEAP_DIV4 = 12'h004;
  localparam logic [YEAR_W-1:0] LEAP_DIV100 = 12'h064;
  localparam logic [YEAR_W-1:0] LEAP_DIV400 = 12'h190;
  // days before the first of each month in a common year
  localparam logic [8:0] MONTH_START [12] = '{9'h000, 9'h01f, 9'h03b, 9'h05a, 9'h078,
    9'h097, 9'h0b5, 9'h0d4, 9'h0f3, 9'h111, 9'h130, 9'h14e};

  // ==========================================================================
  // quantity field; units: 0.1 kWh, 1 W, or 1e-5 base currency
  // ==========================================================================
  localparam int QTY_W = 25;
  localparam int AMT_W = 16;
  localparam int EXP_W = 2;
  localparam int MANT_W = 14;
  localparam int EXP_LSB = 14;
  localparam int NUM_EXP = 4;
  localparam logic [QTY_W-1:0] POW10 [NUM_EXP] = '{25'h0000001, 25'h000000a,
    25'h0000064, 25'h00003e8};
  localparam logic [QTY_W-1:0] EXP_OFFSET [NUM_EXP] = '{25'h0000000, 25'h0004000,
    25'h002c000, 25'h01bc000};
  localparam logic [QTY_W-1:0] EXP_MAX [NUM_EXP] = '{25'h0003fff, 25'h002bff6,
    25'h01bbf9c, 25'h115bc18};

  // gregorian leap year test
  function automatic logic ttac_is_leap(input logic [YEAR_W-1:0] y);
    return ((y % LEAP_DIV4) == '0 && (y % LEAP_DIV100) != '0) || ((y % LEAP_DIV400) == '0);
  endfunction

  // stamp lands on 00:01 of some day
  function automatic logic ttac_is_reserved(input logic [STAMP_W:0] s);
    return (s % (STAMP_W+1)'(MIN_PER_DAY)) == (STAMP_W+1)'(RESERVED_MIN);
  endfunction

  // expand exponent and mantissa to the quantity
  function automatic logic [QTY_W-1:0] ttac_decode_amount(input logic [AMT_W-1:0] f);
    logic [EXP_W-1:0] e;
    logic [QTY_W-1:0] m;
    e = f[AMT_W-1:EXP_LSB];
    m = QTY_W'(f[MANT_W-1:0]);
    return QTY_W'(m * POW10[e]) + EXP_OFFSET[e];
  endfunction

endpackage

// >>> rtl/ttac_minutes.sv
/*
  Elapsed minute counter from the epoch origin to a calendar time.
  Assumes the calendar fields stand while calc_start is high; they are
  latched then. One year is summed per clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ttac_minutes
  import ttac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic calc_start,
  input wire logic [YEAR_W-1:0] origin_year,
  input wire logic [YEAR_W-1:0] year,
  input wire logic [3:0] month,
  input wire logic [4:0] day,
  input wire logic [4:0] hour,
  input wire logic [5:0] minute,
  output logic calc_done,
  output logic [STAMP_W-1:0] minutes,
  output logic calc_err
);

  typedef enum logic [0:0] {TTAC_M_IDLE, TTAC_M_YEARS} ttac_mstate_t;

  localparam int CALC_LAT_MAX = 48;

  ttac_mstate_t state_reg, state_next;
  logic [YEAR_W-1:0] yr_reg, yr_next, tyear_reg, tyear_next;
  logic [3:0] tmon_reg, tmon_next;
  logic [4:0] tday_reg, tday_next, thour_reg, thour_next;
  logic [5:0] tmin_reg, tmin_next;
  logic [15:0] days_reg, days_next;
  logic done_reg, done_next, err_reg, err_next;
  logic [STAMP_W-1:0] min_reg, min_next;
  logic [31:0] day_idx, total;

  // ==========================================================================
  // year walk and final sum
  // ==========================================================================
  always_comb
  begin
    // seconds never enter the sum, so they are truncated
    day_idx = 32'(days_reg) + 32'(MONTH_START[tmon_reg - 4'h1]) + 32'(tday_reg) - 32'h1;
    if (ttac_is_leap(tyear_reg) && tmon_reg > FEB)
    begin
      day_idx = day_idx + 32'h1;
    end
    total = day_idx * 32'(MIN_PER_DAY) + 32'(thour_reg) * 32'(MIN_PER_HOUR) + 32'(tmin_reg);
    state_next = state_reg;
    yr_next = yr_reg;
    tyear_next = tyear_reg;
    tmon_next = tmon_reg;
    tday_next = tday_reg;
    thour_next = thour_reg;
    tmin_next = tmin_reg;
    days_next = days_reg;
    done_next = 1'b0;
    err_next = err_reg;
    min_next = min_reg;
    case (state_reg)
      TTAC_M_IDLE:
        if (calc_start)
        begin
          yr_next = origin_year;
          tyear_next = year;
          tmon_next = month;
          tday_next = day;
          thour_next = hour;
          tmin_next = minute;
          days_next = '0;
          err_next = 1'b0;
          if (year < origin_year || (year - origin_year) > YEAR_SPAN_MAX || month == 4'h0 ||
              month > MONTHS || day == 5'h0)
          begin
            err_next = 1'b1;
            done_next = 1'b1;
            min_next = '0;
          end
          else
          begin
            state_next = TTAC_M_YEARS;
          end
        end
      TTAC_M_YEARS:
        if (yr_reg == tyear_reg)
        begin
          // origin at midnight sums to zero
          min_next = total[STAMP_W-1:0];
          err_next = |total[31:STAMP_W];
          done_next = 1'b1;
          state_next = TTAC_M_IDLE;
        end
        else
        begin
          days_next = days_reg + 16'(DAYS_PER_YEAR) + 16'(ttac_is_leap(yr_reg));
          yr_next = yr_reg + 12'h001;
        end
      default: state_next = TTAC_M_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= TTAC_M_IDLE;
      yr_reg <= '0;
      tyear_reg <= '0;
      tmon_reg <= 4'h1;
      tday_reg <= 5'h01;
      thour_reg <= '0;
      tmin_reg <= '0;
      days_reg <= '0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      min_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      yr_reg <= yr_next;
      tyear_reg <= tyear_next;
      tmon_reg <= tmon_next;
      tday_reg <= tday_next;
      thour_reg <= thour_next;
      tmin_reg <= tmin_next;
      days_reg <= days_next;
      done_reg <= done_next;
      err_reg <= err_next;
      min_reg <= min_next;
    end
  end

  assign calc_done = done_reg;
  assign minutes = min_reg;
  assign calc_err = err_reg;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  calc_finish_a: assert property ((calc_start && state_reg == TTAC_M_IDLE)
    |-> ##[1:CALC_LAT_MAX] calc_done)
    else $error("minute count did not finish");
  year_step_a: assert property ((state_reg == TTAC_M_YEARS && yr_reg != tyear_reg)
    |=> (days_reg - $past(days_reg)) == (16'(DAYS_PER_YEAR) + 16'(ttac_is_leap($past(yr_reg)))))
    else $error("year length wrong");

endmodule

`default_nettype wire

// >>> rtl/ttac_codec.sv
/*
  Vending side codec: turns an issue time into a token time stamp and a
  purchased quantity into the 16-bit quantity field; also expands a
  quantity field back to the quantity.
  Assumes requesters hold their inputs in the request cycle, and that
  same_meter_burst is high for every token of a same-meter burst after
  the first.
*/
`timescale 1ns/1ps
`default_nettype none

module ttac_codec
  import ttac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic stamp_req,
  input wire logic [YEAR_W-1:0] epoch_origin_date,
  input wire logic [YEAR_W-1:0] issue_year,
  input wire logic [3:0] issue_month,
  input wire logic [4:0] issue_day,
  input wire logic [4:0] issue_hour,
  input wire logic [5:0] issue_minute,
  input wire logic special_token,
  input wire logic same_meter_burst,
  output logic stamp_busy,
  output logic stamp_valid,
  output logic [STAMP_W-1:0] token_time_stamp,
  output logic stamp_err,
  input wire logic qty_req,
  input wire logic [QTY_W-1:0] credited_quantity,
  output logic amount_valid,
  output logic [AMT_W-1:0] amount_field,
  output logic amount_err,
  input wire logic field_req,
  input wire logic [AMT_W-1:0] field_in,
  output logic quantity_valid,
  output logic [QTY_W-1:0] decoded_quantity
);

  typedef enum logic [0:0] {TTAC_S_IDLE, TTAC_S_WAIT} ttac_sstate_t;

  localparam int STAMP_LAT_MAX = 50;

  // ==========================================================================
  // minute counter
  // ==========================================================================
  logic calc_start;
  logic calc_done;
  logic calc_err;
  logic [STAMP_W-1:0] calc_minutes;

  ttac_minutes u_minutes (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .calc_start(calc_start),
    .origin_year(epoch_origin_date),
    .year(issue_year),
    .month(issue_month),
    .day(issue_day),
    .hour(issue_hour),
    .minute(issue_minute),
    .calc_done(calc_done),
    .minutes(calc_minutes),
    .calc_err(calc_err)
  );

  // ==========================================================================
  // time stamp sequencing
  // ==========================================================================
  ttac_sstate_t sstate_reg, sstate_next;
  logic special_reg, special_next;
  logic burst_reg, burst_next;
  logic last_valid_reg, last_valid_next;
  logic [STAMP_W-1:0] last_stamp_reg, last_stamp_next;
  logic [STAMP_W-1:0] stamp_reg, stamp_next;
  logic stamp_valid_reg, stamp_valid_next;
  logic stamp_err_reg, stamp_err_next;
  logic [STAMP_W:0] cand;

  assign calc_start = stamp_req && (sstate_reg == TTAC_S_IDLE);

  // pick the stamp from real time, burst sequence and reserved minute
  always_comb
  begin
    cand = {1'b0, calc_minutes};
    // inside a burst each ordinary stamp sits above the last one
    if (!special_reg && burst_reg && last_valid_reg && calc_minutes <= last_stamp_reg)
    begin
      cand = {1'b0, last_stamp_reg} + 25'h0000001;
    end
    // ordinary tokens step over the 00:01 stamp
    if (!special_reg && ttac_is_reserved(cand))
    begin
      cand = cand + 25'h0000001;
    end
    sstate_next = sstate_reg;
    special_next = special_reg;
    burst_next = burst_reg;
    last_valid_next = last_valid_reg;
    last_stamp_next = last_stamp_reg;
    stamp_next = stamp_reg;
    stamp_valid_next = 1'b0;
    stamp_err_next = stamp_err_reg;
    case (sstate_reg)
      TTAC_S_IDLE:
        if (stamp_req)
        begin
          special_next = special_token;
          burst_next = same_meter_burst; // low burst means real time again
          sstate_next = TTAC_S_WAIT;
        end
      TTAC_S_WAIT:
        if (calc_done)
        begin
          stamp_next = cand[STAMP_W-1:0]; // bit 23 is the leftmost bit
          stamp_err_next = calc_err || cand[STAMP_W];
          stamp_valid_next = 1'b1;
          sstate_next = TTAC_S_IDLE;
          // special tokens do not move the burst sequence
          if (!special_reg && !calc_err && !cand[STAMP_W])
          begin
            last_stamp_next = cand[STAMP_W-1:0];
            last_valid_next = 1'b1;
          end
        end
      default: sstate_next = TTAC_S_IDLE;
    endcase
  end

  // stamp registers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sstate_reg <= TTAC_S_IDLE;
      special_reg <= 1'b0;
      burst_reg <= 1'b0;
      last_valid_reg <= 1'b0;
      last_stamp_reg <= '0;
      stamp_reg <= '0;
      stamp_valid_reg <= 1'b0;
      stamp_err_reg <= 1'b0;
    end
    else
    begin
      sstate_reg <= sstate_next;
      special_reg <= special_next;
      burst_reg <= burst_next;
      last_valid_reg <= last_valid_next;
      last_stamp_reg <= last_stamp_next;
      stamp_reg <= stamp_next;
      stamp_valid_reg <= stamp_valid_next;
      stamp_err_reg <= stamp_err_next;
    end
  end

  assign stamp_busy = (sstate_reg != TTAC_S_IDLE);
  assign stamp_valid = stamp_valid_reg;
  assign token_time_stamp = stamp_reg;
  assign stamp_err = stamp_err_reg;

  // ==========================================================================
  // quantity field encode and decode
  // ==========================================================================
  logic [QTY_W-1:0] mant_all [NUM_EXP];
  logic [QTY_W-1:0] diff;
  logic [EXP_W-1:0] enc_exp;
  logic enc_over;
  logic amount_valid_reg, amount_valid_next;
  logic [AMT_W-1:0] amount_reg, amount_next;
  logic amount_err_reg, amount_err_next;
  logic qvalid_reg, qvalid_next;
  logic [QTY_W-1:0] decoded_reg, decoded_next;

  // mantissa for every exponent, each divided up
  always_comb
  begin
    diff = '0;
    for (int i = 0; i < NUM_EXP; i++)
    begin
      diff = (credited_quantity > EXP_OFFSET[i]) ? credited_quantity - EXP_OFFSET[i] : '0;
      mant_all[i] = (diff + POW10[i] - 25'h0000001) / POW10[i];
    end
  end

  // smallest exponent whose range holds the quantity
  always_comb
  begin
    enc_exp = EXP_W'(NUM_EXP - 1);
    for (int i = NUM_EXP - 1; i >= 0; i--)
    begin
      if (credited_quantity <= EXP_MAX[i])
      begin
        enc_exp = EXP_W'(i);
      end
    end
    enc_over = credited_quantity > EXP_MAX[NUM_EXP-1];
  end

  // next values of the quantity outputs
  always_comb
  begin
    amount_valid_next = qty_req;
    amount_next = amount_reg;
    amount_err_next = amount_err_reg;
    qvalid_next = field_req;
    decoded_next = decoded_reg;
    if (qty_req)
    begin
      amount_err_next = enc_over;
      // exponent on top, mantissa below
      amount_next = enc_over ? '1 : {enc_exp, mant_all[enc_exp][MANT_W-1:0]};
    end
    if (field_req)
    begin
      decoded_next = ttac_decode_amount(field_in);
    end
  end

  // quantity registers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      amount_valid_reg <= 1'b0;
      amount_reg <= '0;
      amount_err_reg <= 1'b0;
      qvalid_reg <= 1'b0;
      decoded_reg <= '0;
    end
    else
    begin
      amount_valid_reg <= amount_valid_next;
      amount_reg <= amount_next;
      amount_err_reg <= amount_err_next;
      qvalid_reg <= qvalid_next;
      decoded_reg <= decoded_next;
    end
  end

  assign amount_valid = amount_valid_reg;
  assign amount_field = amount_reg;
  assign amount_err = amount_err_reg;
  assign quantity_valid = qvalid_reg;
  assign decoded_quantity = decoded_reg;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // request taken while idle, answer seen once idle again
  sequence stamp_ask;
    stamp_req && !stamp_busy;
  endsequence

  sequence stamp_out;
    stamp_valid && !stamp_busy;
  endsequence

  // every taken request answers within the longest year walk
  stamp_latency_a: assert property (stamp_ask |-> ##[1:STAMP_LAT_MAX] stamp_out)
    else $error("stamp not produced in time");
  reserved_skip_a: assert property ((stamp_valid && !special_reg && !stamp_err)
    |-> !ttac_is_reserved({1'b0, token_time_stamp}))
    else $error("ordinary token got the reserved stamp");
  special_exact_a: assert property ((stamp_valid && special_reg && !stamp_err)
    |-> token_time_stamp == calc_minutes)
    else $error("special token stamp altered");
  real_time_a: assert property ((stamp_valid && !burst_reg && !special_reg && !stamp_err)
    |-> (token_time_stamp == calc_minutes || token_time_stamp == calc_minutes + 24'h000001))
    else $error("stamp left real time outside burst");
  burst_step_a: assert property ((stamp_valid && burst_reg && !special_reg && !stamp_err
    && $past(last_valid_reg)) |-> token_time_stamp > $past(last_stamp_reg))
    else $error("burst stamp not above previous");
  round_up_a: assert property ((amount_valid && !amount_err)
    |-> (ttac_decode_amount(amount_field) >= $past(credited_quantity)) &&
        (ttac_decode_amount(amount_field) - $past(credited_quantity)
         < POW10[amount_field[AMT_W-1:EXP_LSB]]))
    else $error("quantity not rounded up to next value");
  smallest_exp_a: assert property ((amount_valid && !amount_err &&
    amount_field[AMT_W-1:EXP_LSB] != '0) |->
    $past(credited_quantity) > EXP_MAX[amount_field[AMT_W-1:EXP_LSB] - 2'h1])
    else $error("exponent larger than needed");
  over_flag_a: assert property (amount_valid
    |-> amount_err == ($past(credited_quantity) > EXP_MAX[NUM_EXP-1]))
    else $error("range error flag wrong");
  decode_value_a: assert property (field_req |=> quantity_valid &&
    decoded_quantity == ttac_decode_amount($past(field_in)))
    else $error("decoded quantity wrong");
  // a taken request makes the sequencer busy in the next cycle
  busy_span_a: assert property (stamp_ask |=> stamp_busy)
    else $error("stamp request not taken");
  // each quantity request is answered in the next cycle
  amount_next_a: assert property (qty_req |=> amount_valid)
    else $error("quantity field not produced");
  // the field stands between requests
  field_hold_a: assert property (!qty_req |=> $stable(amount_field))
    else $error("quantity field changed without request");

endmodule

`default_nettype wire

// >>> sim/ttac_meter_model.sv
/*
  Meter side model: expands the 16-bit quantity field sent by the codec
  back into the credited quantity, as a paying meter would.
  Assumes the field is read combinationally while amount_valid is high.
*/
`timescale 1ns/1ps
`default_nettype none

module ttac_meter_model
  import ttac_pkg::*;
(
  input wire logic [AMT_W-1:0] amount_field,
  output logic [QTY_W-1:0] meter_qty
);
  logic [QTY_W-1:0] mant;
  logic [QTY_W-1:0] scale;
  logic [QTY_W-1:0] offs;

  // ==========================================================================
  // field expansion
  // ==========================================================================
  // scale walks the powers of ten while the range offsets pile up
  always_comb
  begin
    mant = QTY_W'(amount_field[13:0]);
    scale = 25'h0000001;
    offs = 25'h0000000;
    for (int n = 1; n <= 3; n++)
    begin
      if (amount_field[15:14] >= 2'(n))
      begin
        offs = offs + 25'h0004000 * scale;
        scale = scale * 25'h000000a;
      end
    end
    meter_qty = mant * scale + offs;
  end
endmodule

`default_nettype wire

// >>> sim/tb.sv
/*
  Self-checking bench of the codec: time stamps with leap years, reserved
  minute and same-meter bursts, then quantity encoding and decoding.
  Assumes the codec contract: inputs change 1 ns after the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module tb
  import ttac_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic stamp_req = 1'b0;
  logic [YEAR_W-1:0] origin = '0;
  logic [YEAR_W-1:0] year = '0;
  logic [3:0] month = '0;
  logic [4:0] day = '0;
  logic [4:0] hour = '0;
  logic [5:0] minute = '0;
  logic special = 1'b0;
  logic burst = 1'b0;
  logic want_err = 1'b0;
  logic stamp_busy, stamp_valid, stamp_err, amount_valid, amount_err, quantity_valid;
  logic [STAMP_W-1:0] token_time_stamp;
  logic qty_req = 1'b0;
  logic [QTY_W-1:0] credited_quantity = '0;
  logic [AMT_W-1:0] amount_field;
  logic field_req = 1'b0;
  logic [AMT_W-1:0] field_in = '0;
  logic [QTY_W-1:0] decoded_quantity, meter_qty;
  int n_errors = 0;
  int total_checks = 0;
  // quantities, fields and meter readings at the range edges
  logic [31:0] aq [10] = '{32'h0, 32'h3fff, 32'h4000, 32'h4001, 32'h2bff6, 32'h2bff7,
    32'h1bbf9c, 32'h1bbf9d, 32'h115bc18, 32'h115bc19};
  logic [31:0] af [10] = '{32'h0, 32'h3fff, 32'h4000, 32'h4001, 32'h7fff, 32'h8000,
    32'hbfff, 32'hc000, 32'hffff, 32'hffff};
  logic [31:0] at [10] = '{32'h0, 32'h3fff, 32'h4000, 32'h400a, 32'h2bff6, 32'h2c000,
    32'h1bbf9c, 32'h1bc000, 32'h115bc18, 32'h115bc18};
  logic [31:0] df [9] = '{32'h1, 32'h100, 32'h3fff, 32'h4000, 32'h7fff, 32'h8000,
    32'hbfff, 32'hc000, 32'hffff};

  // ==========================================================================
  // design and meter model
  // ==========================================================================
  ttac_codec i_dut (.ref_clk(ref_clk), .rstn(rstn), .stamp_req(stamp_req),
    .epoch_origin_date(origin), .issue_year(year), .issue_month(month), .issue_day(day),
    .issue_hour(hour), .issue_minute(minute), .special_token(special),
    .same_meter_burst(burst), .stamp_busy(stamp_busy), .stamp_valid(stamp_valid),
    .token_time_stamp(token_time_stamp), .stamp_err(stamp_err), .qty_req(qty_req),
    .credited_quantity(credited_quantity), .amount_valid(amount_valid),
    .amount_field(amount_field), .amount_err(amount_err), .field_req(field_req),
    .field_in(field_in), .quantity_valid(quantity_valid),
    .decoded_quantity(decoded_quantity));
  ttac_meter_model i_meter (.amount_field(amount_field), .meter_qty(meter_qty));

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // ==========================================================================
  // compare and closing tasks
  // ==========================================================================
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  // one stamp request, wait for the answer and judge it
  task automatic do_stamp(input int oy, input int y, input int mo, input int d,
    input int h, input int mi, input logic sp, input logic bu, input logic [23:0] exp);
    int n;
    @(posedge ref_clk);
    #1;
    origin = YEAR_W'(oy);
    year = YEAR_W'(y);
    month = 4'(mo);
    day = 5'(d);
    hour = 5'(h);
    minute = 6'(mi);
    special = sp;
    burst = bu;
    stamp_req = 1'b1;
    @(posedge ref_clk);
    #1;
    stamp_req = 1'b0;
    chk_flag(stamp_busy, 1'b1); // request taken
    n = 0;
    while (stamp_valid !== 1'b1 && n < 60)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk_flag(stamp_valid, 1'b1); // answer within bound
    chk_val({8'h0, token_time_stamp}, {8'h0, exp}); // whole stamp, msb first
    chk_flag(stamp_err, want_err); // error flag only for bad requests
    chk_flag(stamp_busy, 1'b0); // free again with the answer
  endtask

  // bad dates and years before the origin answer with the error flag
  task automatic stamp_err_test();
    want_err = 1'b1;
    do_stamp(1993, 1993, 0, 1, 0, 0, 1'b0, 1'b0, 24'h000000); // month zero
    do_stamp(1993, 1992, 1, 1, 0, 0, 1'b0, 1'b0, 24'h000000); // before origin
    want_err = 1'b0;
  endtask

  // back-to-back quantity encodes, meter model reads each field
  task automatic amount_test();
    for (int i = 0; i <= 10; i++)
    begin
      @(posedge ref_clk);
      #1;
      if (i > 0)
      begin
        chk_flag(amount_valid, 1'b1); // one cycle answer
        chk_val({16'h0, amount_field}, af[i-1]); // field
        chk_flag(amount_err, i == 10); // over range
        chk_val({7'h0, meter_qty}, at[i-1]); // rounded up
      end
      qty_req = (i < 10);
      credited_quantity = aq[i % 10][24:0];
    end
  endtask

  // back-to-back field expansions
  task automatic decode_test();
    logic [24:0] exp;
    for (int i = 0; i <= 9; i++)
    begin
      @(posedge ref_clk);
      #1;
      if (i > 0)
      begin
        case (i)
          1: exp = 25'h0000001;
          2: exp = 25'h0000100;
          3: exp = 25'h0003fff;
          4: exp = 25'h0004000;
          5: exp = 25'h002bff6;
          6: exp = 25'h002c000;
          7: exp = 25'h01bbf9c;
          8: exp = 25'h01bc000;
          default: exp = 25'h115bc18;
        endcase
        chk_flag(quantity_valid, 1'b1); // one cycle answer
        chk_val({7'h0, decoded_quantity}, {7'h0, exp}); // expansion
      end
      field_req = (i < 9);
      field_in = df[i % 9][15:0];
    end
  endtask

  // ==========================================================================
  // main sequence and watchdog
  // ==========================================================================
  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    do_stamp(1993, 1993, 1, 1, 0, 0, 1'b0, 1'b0, 24'h000000); // origin is zero
    do_stamp(1993, 1993, 1, 1, 0, 1, 1'b1, 1'b0, 24'h000001); // special
    do_stamp(1993, 1993, 1, 1, 0, 1, 1'b0, 1'b0, 24'h000002); // ordinary skips
    do_stamp(1993, 1993, 3, 25, 13, 55, 1'b0, 1'b0, 24'h01d623); // elapsed
    do_stamp(1993, 1993, 3, 25, 13, 55, 1'b0, 1'b1, 24'h01d624); // second of burst
    do_stamp(1993, 1993, 3, 25, 13, 55, 1'b0, 1'b1, 24'h01d625); // third of burst
    do_stamp(1993, 1993, 3, 25, 13, 55, 1'b1, 1'b1, 24'h01d623); // special no bump
    do_stamp(1993, 1993, 3, 25, 13, 55, 1'b0, 1'b0, 24'h01d623); // back to real
    do_stamp(1993, 1996, 3, 25, 13, 55, 1'b0, 1'b0, 24'h19eb23); // leap year
    do_stamp(1993, 2005, 11, 1, 0, 1, 1'b0, 1'b0, 24'h66fc62); // reserved day
    do_stamp(1993, 2005, 11, 1, 0, 1, 1'b1, 1'b0, 24'h66fc61); // special
    do_stamp(1996, 2000, 3, 1, 0, 0, 1'b0, 1'b0, 24'h216ba0); // century leap
    do_stamp(2090, 2100, 3, 1, 0, 0, 1'b0, 1'b0, 24'h518a60); // century common
    stamp_err_test(); // bad requests flagged
    amount_test();
    decode_test();
    tally_and_finish();
  end

  // cut a hang short
  initial
  begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
